// ---- core/hcr_pkg.sv ----
package hcr_pkg;

	// ****************************************************************
	// host port addresses
	// ****************************************************************
	localparam int          ADDR_W        = 3;
	localparam int          DATA_W        = 8;
	localparam logic [2:0]  ADDR_STATUS   = 3'h0;
	localparam logic [2:0]  ADDR_COMMAND  = 3'h0;
	localparam logic [2:0]  ADDR_PARAM    = 3'h1;
	localparam logic [2:0]  ADDR_RESULT   = 3'h1;
	localparam logic [2:0]  ADDR_TX_IRES  = 3'h2;
	localparam logic [2:0]  ADDR_RX_IRES  = 3'h3;
	localparam logic [2:0]  ADDR_RX_DATA  = 3'h4;
	localparam logic [2:0]  ADDR_TX_DATA  = 3'h5;

	// ****************************************************************
	// status field positions and reset values
	// ****************************************************************
	localparam int          ST_BUSY       = 7;
	localparam int          ST_CMD_PEND   = 6;
	localparam int          ST_PARAM_FULL = 5;
	localparam int          ST_IMM_READY  = 4;
	localparam int          ST_RX_SREQ    = 3;
	localparam int          ST_TX_SREQ    = 2;
	localparam int          ST_RX_AVAIL   = 1;
	localparam int          ST_TX_AVAIL   = 0;
	localparam logic [7:0]  BYTE_RESET    = 8'h00;
	localparam logic [7:0]  UNMAPPED_READ = 8'h00;

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic             sel;
		logic             rd;
		logic             wr;
		logic [2:0]       addr;
		logic [7:0]       wdata;
	} host_bus_type;

	typedef struct packed {
		logic             load;
		logic [7:0]       data;
	} result_load_type;

	typedef enum logic [1:0] {
		DIR_RX,
		DIR_TX
	} direction_type;

endpackage

// ---- core/host_command_result_handshake.sv ----
// Function
// RQ1: busy flag set on command write, cleared when final parameter accepted.
// RQ2: command-pending flag high while an unconsumed command byte is held.
// RQ3: parameter-full set on parameter write, cleared when device takes it.
// RQ4: immediate-ready set on result load, cleared when host reads result.
// RQ5: receive request bit mirrors pin; set on need, cleared on service.
// RQ6: transmit request bit and pin act like receive, from transmit causes.
// RQ7: receive result flag set on result byte load, cleared on host read.
// RQ8: transmit result flag set on result byte load, cleared on host read.
// RQ9: host must not write command while busy; else pending one is lost.
// RQ10: host waits for parameter-full clear; early write loses old one.
// RQ11: one command register, so only one command phase at a time.
// RQ12: receive and transmit run independently, own pins and result regs.
// RQ13: request with result flag 0 means data transfer, 1 means completion.
// RQ14: host reads matching result register when result flag found set.
// RQ15: in DMA mode no data-transfer service requests are raised.
// RQ16: immediate results appear at once, only in immediate result register.
// RQ17: host polls until immediate-ready is 1, then reads result register.
// RQ18: result phase entered on successful completion or on detected error.
// RQ19: host writes command byte, then parameter bytes to parameter register.
// RQ20: sender should use inverted-transition coding for clock recovery lock.
// RQ21: after idle, sync characters should give at least 12 transitions.
// RQ22: each non-immediate result is a code byte plus optional extra bytes.
// RQ23: request stays asserted until every result byte has been consumed.
// RQ24: status register is eight bits, busy flag in most significant bit.
// RQ25: reset clears all handshake and result flags and both request pins.
module host_command_result_handshake (
	input  wire logic                    mclk_i,
	input  wire logic                    reset_n_i,
	input  wire hcr_pkg::host_bus_type   host_i,
	output logic [7:0]                   rdata_o,
	output logic                         rdata_valid_o,
	input  wire logic                    dma_mode_i,
	input  wire logic                    core_cmd_take_i,
	input  wire logic                    core_param_take_i,
	input  wire logic                    core_phase_done_i,
	input  wire hcr_pkg::result_load_type core_imm_result_i,
	input  wire hcr_pkg::result_load_type core_rx_result_i,
	input  wire hcr_pkg::result_load_type core_tx_result_i,
	input  wire logic                    core_rx_more_i,
	input  wire logic                    core_tx_more_i,
	input  wire logic                    core_rx_dreq_i,
	input  wire logic                    core_tx_dreq_i,
	input  wire logic [7:0]              core_rx_data_i,
	output logic [7:0]                   command_byte_o,
	output logic                         command_byte_pending_o,
	output logic [7:0]                   parameter_byte_o,
	output logic                         parameter_buffer_full_o,
	output logic                         command_phase_busy_o,
	output logic                         receive_service_request_o,
	output logic                         transmit_service_request_o,
	output logic                         receive_result_available_o,
	output logic                         transmit_result_available_o,
	output logic                         rx_data_taken_o,
	output logic [7:0]                   tx_data_o,
	output logic                         tx_data_strobe_o
);

	// ****************************************************************
	// host strobe decode
	// ****************************************************************
	function automatic logic hit(input hcr_pkg::host_bus_type b,
		input logic rd, input logic [2:0] a);
		hit = b.sel && (rd ? b.rd : b.wr) && (b.addr == a);
	endfunction

	logic wr_command;
	logic wr_param;
	logic wr_tx_data;
	logic rd_result;
	logic rd_tx_ires;
	logic rd_rx_ires;
	logic rd_rx_data;
	logic rd_any;

	assign wr_command = hit(host_i, 1'b0, hcr_pkg::ADDR_COMMAND);
	assign wr_param   = hit(host_i, 1'b0, hcr_pkg::ADDR_PARAM);
	assign wr_tx_data = hit(host_i, 1'b0, hcr_pkg::ADDR_TX_DATA);
	assign rd_result  = hit(host_i, 1'b1, hcr_pkg::ADDR_RESULT);
	assign rd_tx_ires = hit(host_i, 1'b1, hcr_pkg::ADDR_TX_IRES);
	assign rd_rx_ires = hit(host_i, 1'b1, hcr_pkg::ADDR_RX_IRES);
	assign rd_rx_data = hit(host_i, 1'b1, hcr_pkg::ADDR_RX_DATA);
	assign rd_any     = host_i.sel && host_i.rd;

	// ****************************************************************
	// command register and command phase
	// ****************************************************************
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			command_byte_o <= hcr_pkg::BYTE_RESET;
		end else if (wr_command) begin
			// a write while busy simply overwrites [RQ9] [RQ11] [RQ19]
			command_byte_o <= host_i.wdata;
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			command_byte_pending_o <= 1'b0; // [RQ25]
		end else if (wr_command) begin
			command_byte_pending_o <= 1'b1; // [RQ2]
		end else if (core_cmd_take_i) begin
			command_byte_pending_o <= 1'b0; // [RQ2]
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			command_phase_busy_o <= 1'b0; // [RQ25]
		end else if (wr_command) begin
			command_phase_busy_o <= 1'b1; // [RQ1]
		end else if (core_phase_done_i) begin
			command_phase_busy_o <= 1'b0; // [RQ1]
		end
	end

	// ****************************************************************
	// parameter register
	// ****************************************************************
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			parameter_byte_o <= hcr_pkg::BYTE_RESET;
		end else if (wr_param) begin
			// early write replaces the held parameter [RQ10]
			parameter_byte_o <= host_i.wdata;
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			parameter_buffer_full_o <= 1'b0; // [RQ25]
		end else if (wr_param) begin
			parameter_buffer_full_o <= 1'b1; // [RQ3]
		end else if (core_param_take_i) begin
			parameter_buffer_full_o <= 1'b0; // [RQ3]
		end
	end

	// ****************************************************************
	// immediate result register
	// ****************************************************************
	logic [7:0] imm_result;
	logic       imm_ready;

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			imm_result <= hcr_pkg::BYTE_RESET;
		end else if (core_imm_result_i.load) begin
			// only immediate results land here [RQ16]
			imm_result <= core_imm_result_i.data;
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			imm_ready <= 1'b0; // [RQ25]
		end else if (core_imm_result_i.load) begin
			imm_ready <= 1'b1; // [RQ4] [RQ17]
		end else if (rd_result) begin
			imm_ready <= 1'b0; // [RQ4]
		end
	end

	// ****************************************************************
	// interrupt result registers, one per direction
	// ****************************************************************
	logic [7:0] rx_ires;
	logic [7:0] tx_ires;

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rx_ires <= hcr_pkg::BYTE_RESET;
		end else if (core_rx_result_i.load) begin
			// code byte then extra bytes, one load each [RQ18] [RQ22]
			rx_ires <= core_rx_result_i.data;
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tx_ires <= hcr_pkg::BYTE_RESET;
		end else if (core_tx_result_i.load) begin
			tx_ires <= core_tx_result_i.data; // [RQ12] [RQ18] [RQ22]
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			receive_result_available_o <= 1'b0; // [RQ25]
		end else if (core_rx_result_i.load) begin
			receive_result_available_o <= 1'b1; // [RQ7]
		end else if (rd_rx_ires) begin
			receive_result_available_o <= 1'b0; // [RQ7] [RQ14]
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			transmit_result_available_o <= 1'b0; // [RQ25]
		end else if (core_tx_result_i.load) begin
			transmit_result_available_o <= 1'b1; // [RQ8]
		end else if (rd_tx_ires) begin
			transmit_result_available_o <= 1'b0; // [RQ8] [RQ14]
		end
	end

	// ****************************************************************
	// data transfer requests and service request pins
	// ****************************************************************
	logic rx_dreq;
	logic tx_dreq;

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rx_dreq <= 1'b0;
		end else if (core_rx_dreq_i && !dma_mode_i) begin
			rx_dreq <= 1'b1; // [RQ15]
		end else if (rd_rx_data || dma_mode_i) begin
			rx_dreq <= 1'b0; // [RQ5]
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tx_dreq <= 1'b0;
		end else if (core_tx_dreq_i && !dma_mode_i) begin
			tx_dreq <= 1'b1; // [RQ15]
		end else if (wr_tx_data || dma_mode_i) begin
			tx_dreq <= 1'b0; // [RQ6]
		end
	end

	// request pin follows its causes one clock later; the flag shows why
	logic next_rx_sreq;
	logic next_tx_sreq;

	always_comb begin
		// [RQ5] [RQ13] [RQ23]
		next_rx_sreq = rx_dreq || receive_result_available_o
			|| core_rx_more_i;
		// [RQ6] [RQ13] [RQ23]
		next_tx_sreq = tx_dreq || transmit_result_available_o
			|| core_tx_more_i;
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			receive_service_request_o  <= 1'b0; // [RQ25]
			transmit_service_request_o <= 1'b0; // [RQ25]
		end else begin
			receive_service_request_o  <= next_rx_sreq; // [RQ12]
			transmit_service_request_o <= next_tx_sreq; // [RQ12]
		end
	end

	// ****************************************************************
	// host data transfer strobes
	// ****************************************************************
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tx_data_o        <= hcr_pkg::BYTE_RESET;
			tx_data_strobe_o <= 1'b0;
			rx_data_taken_o  <= 1'b0;
		end else begin
			tx_data_strobe_o <= wr_tx_data;
			rx_data_taken_o  <= rd_rx_data;
			if (wr_tx_data) begin
				tx_data_o <= host_i.wdata;
			end
		end
	end

	// ****************************************************************
	// status register and read data
	// ****************************************************************
	logic [7:0] status;

	always_comb begin
		status = hcr_pkg::BYTE_RESET;
		status[hcr_pkg::ST_BUSY]       = command_phase_busy_o; // [RQ24]
		status[hcr_pkg::ST_CMD_PEND]   = command_byte_pending_o;
		status[hcr_pkg::ST_PARAM_FULL] = parameter_buffer_full_o;
		status[hcr_pkg::ST_IMM_READY]  = imm_ready;
		status[hcr_pkg::ST_RX_SREQ]    = receive_service_request_o; // [RQ5]
		status[hcr_pkg::ST_TX_SREQ]    = transmit_service_request_o; // [RQ6]
		status[hcr_pkg::ST_RX_AVAIL]   = receive_result_available_o;
		status[hcr_pkg::ST_TX_AVAIL]   = transmit_result_available_o;
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_o       <= hcr_pkg::BYTE_RESET;
			rdata_valid_o <= 1'b0;
		end else begin
			rdata_valid_o <= rd_any;
			if (rd_any) begin
				unique case (host_i.addr)
					hcr_pkg::ADDR_STATUS:  rdata_o <= status;
					hcr_pkg::ADDR_RESULT:  rdata_o <= imm_result;
					hcr_pkg::ADDR_TX_IRES: rdata_o <= tx_ires;
					hcr_pkg::ADDR_RX_IRES: rdata_o <= rx_ires;
					hcr_pkg::ADDR_RX_DATA: rdata_o <= core_rx_data_i;
					default:               rdata_o <= hcr_pkg::UNMAPPED_READ;
				endcase
			end
		end
	end

endmodule

// ---- verification/hcr_chk.sv ----
module hcr_chk (
	input  wire logic                    mclk_i,
	input  wire logic                    reset_n_i,
	input  wire hcr_pkg::host_bus_type   host_i,
	input  wire logic [7:0]              rdata_o,
	input  wire logic                    rdata_valid_o,
	input  wire logic                    core_param_take_i,
	input  wire logic                    core_phase_done_i,
	input  wire hcr_pkg::result_load_type core_rx_result_i,
	input  wire hcr_pkg::result_load_type core_tx_result_i,
	input  wire logic                    command_phase_busy_o,
	input  wire logic                    command_byte_pending_o,
	input  wire logic                    parameter_buffer_full_o,
	input  wire logic                    receive_service_request_o,
	input  wire logic                    receive_result_available_o,
	input  wire logic                    transmit_result_available_o,
	input  wire logic                    transmit_service_request_o,
	input  wire logic                    rx_data_taken_o,
	input  wire logic                    tx_data_strobe_o,
	input  wire logic [7:0]              tx_data_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);

	// ************************************************
	// decoded host accesses
	// ************************************************
	wire logic rd = host_i.sel && host_i.rd;
	wire logic cw = host_i.sel && host_i.wr && host_i.addr == 3'h0;
	wire logic pw = host_i.sel && host_i.wr && host_i.addr == 3'h1;

	// ************************************************
	// properties
	// ************************************************
	property p_busy_set;
		cw |=> command_phase_busy_o && command_byte_pending_o;
	endproperty
	a_busy_set: assert property (p_busy_set)
		else $error("busy or pending not set by command");
	property p_busy_clr;
		core_phase_done_i && !cw |=> !command_phase_busy_o;
	endproperty
	a_busy_clr: assert property (p_busy_clr)
		else $error("busy not cleared at phase end");
	property p_busy_hold;
		core_param_take_i && command_phase_busy_o && !core_phase_done_i
			|=> command_phase_busy_o;
	endproperty
	a_busy_hold: assert property (p_busy_hold)
		else $error("busy cleared by parameter take");
	property p_pf_set;
		pw |=> parameter_buffer_full_o;
	endproperty
	a_pf_set: assert property (p_pf_set)
		else $error("parameter full not set");
	property p_pf_clr;
		core_param_take_i && !pw |=> !parameter_buffer_full_o;
	endproperty
	a_pf_clr: assert property (p_pf_clr)
		else $error("parameter full not cleared");
	property p_rx_set;
		core_rx_result_i.load
			|=> receive_result_available_o ##1 receive_service_request_o;
	endproperty
	a_rx_set: assert property (p_rx_set)
		else $error("receive result flag or request missing");
	property p_rx_clr;
		rd && host_i.addr == 3'h3 && !core_rx_result_i.load
			|=> !receive_result_available_o;
	endproperty
	a_rx_clr: assert property (p_rx_clr)
		else $error("receive result flag not cleared");
	property p_tx_clr;
		rd && host_i.addr == 3'h2 && !core_tx_result_i.load
			|=> !transmit_result_available_o;
	endproperty
	a_tx_clr: assert property (p_tx_clr)
		else $error("transmit result flag not cleared");
	property p_tx_set;
		core_tx_result_i.load
			|=> transmit_result_available_o ##1 transmit_service_request_o;
	endproperty
	a_tx_set: assert property (p_tx_set)
		else $error("transmit result flag or request missing");
	property p_rx_taken;
		rd && host_i.addr == 3'h4 |=> rx_data_taken_o;
	endproperty
	a_rx_taken: assert property (p_rx_taken)
		else $error("receive data read not passed on");
	property p_tx_strobe;
		host_i.sel && host_i.wr && host_i.addr == 3'h5
			|=> tx_data_strobe_o && tx_data_o == $past(host_i.wdata);
	endproperty
	a_tx_strobe: assert property (p_tx_strobe)
		else $error("transmit data write not passed on");
	property p_stat;
		rd && host_i.addr == 3'h0 |=> rdata_valid_o
			&& rdata_o[7] == $past(command_phase_busy_o)
			&& rdata_o[1] == $past(receive_result_available_o);
	endproperty
	a_stat: assert property (p_stat)
		else $error("status byte does not match flags");

	c_cmd: cover property (cw ##1 command_phase_busy_o);
	c_done: cover property (receive_service_request_o
		&& receive_result_available_o);
	c_dreq: cover property (receive_service_request_o
		&& !receive_result_available_o);
endmodule

bind host_command_result_handshake hcr_chk chk (.mclk_i, .reset_n_i,
	.host_i, .rdata_o, .rdata_valid_o, .core_param_take_i,
	.core_phase_done_i, .core_rx_result_i, .core_tx_result_i,
	.command_phase_busy_o, .command_byte_pending_o,
	.parameter_buffer_full_o, .receive_service_request_o,
	.receive_result_available_o, .transmit_result_available_o,
	.transmit_service_request_o, .rx_data_taken_o, .tx_data_strobe_o,
	.tx_data_o);

// ---- verification/hcr_host_model.sv ----
module hcr_host_model (
	input  wire logic                  mclk_i,
	input  wire logic [7:0]            rdata_i,
	output hcr_pkg::host_bus_type      host_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// ************************************************
	// host processor: access makes one bus access per call; poll, send and imm are built from it
	// ************************************************
	initial host_o = '0;

	task automatic access(input logic w, input logic [2:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge mclk_i);
		host_o <= '{1'b1, !w, w, a, d};
		@(posedge mclk_i);
		host_o <= '{1'b0, 1'b0, 1'b0, ~a, ~d};
		#1;
		q = rdata_i;
	endtask

	task automatic poll(input int b, input logic v, output logic ok);
		logic [7:0] q;
		ok = 1'b0;
		for (int i = 0; i < 40 && !ok; i++) begin
			access(1'b0, hcr_pkg::ADDR_STATUS, 8'h00, q);
			ok = (q[b] === v);
		end
	endtask

	// checked write: command waits for idle, parameter for empty buffer
	task automatic send(input logic [2:0] a, input logic [7:0] d,
		output logic ok);
		logic [7:0] q;
		poll(a == 3'h0 ? hcr_pkg::ST_BUSY : hcr_pkg::ST_PARAM_FULL, 1'b0,
			ok);
		access(1'b1, a, d, q);
	endtask

	task automatic imm(output logic [7:0] q, output logic ok);
		poll(hcr_pkg::ST_IMM_READY, 1'b1, ok);
		access(1'b0, hcr_pkg::ADDR_RESULT, 8'h00, q);
	endtask

	// far station sync: with inverted-transition coding each zero
	// bit toggles the line
	function automatic logic [7:0] sync_transitions(input logic [7:0] c,
		input logic [7:0] n);
		sync_transitions = 8'h00;
		for (int i = 0; i < 8; i++)
			if (!c[i]) sync_transitions = sync_transitions + n;
	endfunction
endmodule

// ---- verification/host_command_result_handshake_bench.sv ----
module host_command_result_handshake_bench;
	timeunit 1ns;
	timeprecision 1ns;

	logic                        mclk_i = 1'b0;
	logic                        reset_n_i = 1'b0;
	logic                        dma_mode_i = 1'b0;
	logic [7:0]                  pul = 8'h00;
	logic [2:0]                  mo = 3'h0;
	hcr_pkg::result_load_type    res [3] = '{default: '0};
	hcr_pkg::host_bus_type       host_i;
	logic [7:0]                  rdata_o, command_byte_o;
	logic [7:0]                  parameter_byte_o, tx_data_o;
	int                          err_total = 0;
	int                          compares = 0;

	always #25 mclk_i = ~mclk_i;

	host_command_result_handshake uut (.mclk_i, .reset_n_i, .host_i,
		.rdata_o, .rdata_valid_o(), .dma_mode_i,
		.core_cmd_take_i(pul[0]), .core_param_take_i(pul[1]),
		.core_phase_done_i(pul[2]), .core_imm_result_i(res[0]),
		.core_rx_result_i(res[1]), .core_tx_result_i(res[2]),
		.core_rx_more_i(mo[1]), .core_tx_more_i(mo[2]),
		.core_rx_dreq_i(pul[3]), .core_tx_dreq_i(pul[4]),
		.core_rx_data_i(8'hC3), .command_byte_o,
		.command_byte_pending_o(), .parameter_byte_o,
		.parameter_buffer_full_o(), .command_phase_busy_o(),
		.receive_service_request_o(), .transmit_service_request_o(),
		.receive_result_available_o(), .transmit_result_available_o(),
		.rx_data_taken_o(), .tx_data_o, .tx_data_strobe_o());
	hcr_host_model h (.mclk_i, .rdata_i(rdata_o), .host_o(host_i));

	// ************************************************
	// tasks
	// ************************************************
	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e,
		input logic [7:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic okc(input logic ok);
		if (ok !== 1'b1) begin
			err_total++;
			conclude();
		end
	endtask
	task automatic cr(input logic [2:0] a, input logic [7:0] e, string n);
		logic [7:0] q;
		h.access(1'b0, a, 8'h00, q);
		chk(n, e, q);
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		logic [7:0] q;
		h.access(1'b1, a, d, q);
	endtask
	task automatic pulse(input logic [7:0] m);
		@(posedge mclk_i);
		pul <= m;
		@(posedge mclk_i);
		pul <= 8'h00;
	endtask
	task automatic ld(input int d, input logic [7:0] v, input logic more);
		@(posedge mclk_i);
		res[d] <= '{1'b1, v};
		mo[d] <= more;
		@(posedge mclk_i);
		res[d].load <= 1'b0;
	endtask

	// ************************************************
	// tests
	// ************************************************
	initial begin
		logic ok;
		logic [7:0] q, m;
		logic [2:0] a;
		repeat (10) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		cr(3'h0, 8'h00, "status after reset");
		$display("test reset done");
		h.send(3'h0, 8'hA5, ok);
		okc(ok);
		h.send(3'h1, 8'h3C, ok);
		okc(ok);
		cr(3'h0, 8'hE0, "status");
		chk("command byte", 8'hA5, command_byte_o);
		pulse(8'h01);
		cr(3'h0, 8'hA0, "status");
		pulse(8'h02);
		cr(3'h0, 8'h80, "status");
		wr(3'h1, 8'h11);
		wr(3'h1, 8'h22);
		chk("parameter byte", 8'h22, parameter_byte_o);
		wr(3'h0, 8'h77);
		chk("command byte", 8'h77, command_byte_o);
		pulse(8'h07);
		cr(3'h0, 8'h00, "status");
		$display("test command done");
		ld(0, 8'h5A, 1'b0);
		cr(3'h0, 8'h10, "status");
		h.imm(q, ok);
		okc(ok);
		chk("immediate result", 8'h5A, q);
		cr(3'h0, 8'h00, "status");
		$display("test immediate done");
		for (int d = 1; d < 3; d++) begin
			m = (d == 1) ? 8'h0A : 8'h05;
			a = (d == 1) ? 3'h3 : 3'h2;
			ld(d, 8'h80, 1'b1);
			cr(3'h0, m, "status");
			cr(a, 8'h80, "result code");
			cr(3'h0, m & 8'h0C, "status");
			ld(d, 8'h41, 1'b0);
			cr(a, 8'h41, "result extra");
			cr(3'h0, 8'h00, "status");
		end
		$display("test results done");
		pulse(8'h18);
		cr(3'h0, 8'h0C, "status");
		cr(3'h4, 8'hC3, "receive data");
		cr(3'h0, 8'h04, "status");
		wr(3'h5, 8'h99);
		cr(3'h0, 8'h00, "status");
		chk("transmit data", 8'h99, tx_data_o);
		@(posedge mclk_i);
		dma_mode_i <= 1'b1;
		pulse(8'h18);
		cr(3'h0, 8'h00, "status");
		@(posedge mclk_i);
		dma_mode_i <= 1'b0;
		cr(3'h6, 8'h00, "unmapped read");
		chk("sync transitions", 8'h10,
			h.sync_transitions(8'h00, 8'h02));
		$display("test transfer done");
		conclude();
	end
endmodule
